// >>> verilog/atw_dev.sv
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module atw_dev (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	atw_link_if.dev              link,
	input  wire logic            ecc_sel_load,
	input  wire logic            ecc_sel_40,
	output wire logic            media_wr,
	output wire logic            media_long,
	output wire logic            media_lba_mode,
	output wire logic [27:0]     media_addr,
	output wire logic [5:0]      media_ecc_len,
	input  wire logic [8:0]      media_idx,
	output wire logic [15:0]     media_word,
	input  wire logic            media_done,
	input  wire logic            media_unc
);
	import atw_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_BUF_WR, S_BUF_RD, S_DMA, S_LONG, S_ECC, S_MEDIA
	} atw_dstate_e;

	typedef struct packed {
		atw_dstate_e st;
		logic [7:0]  err_reg;
		logic [7:0]  count;
		logic [7:0]  sect;
		logic [7:0]  trk_lo;
		logic [7:0]  trk_hi;
		logic [7:0]  drvhd;
		logic        err;
		logic        intrq;
		logic        dmarq;
		logic        long_cmd;
		logic        ecc40;
		logic        media_wr;
		logic [8:0]  remain;
		logic [8:0]  ptr;
		logic [5:0]  ecc_idx;
		logic [15:0] rdata;
		logic [15:0] media_word;
	} atw_dev_s;

	// ----------------------------------------
	// address stepping
	// ----------------------------------------
	// chs geometry is fixed; lba is a plain 28-bit increment
	function automatic logic [27:0] atw_next_addr(input logic lba, input logic [27:0] a);
		logic [27:0] r;
		r = a + 28'h000_0001;
		if (!lba) begin
			r = a;
			if (a[7:0] == SECT_PER_TRK) begin
				r[7:0] = 8'h01;
				if (a[27:24] == HEAD_LAST) begin
					r[27:24] = 4'h0;
					r[23:8]  = a[23:8] + 16'h0001;
				end else begin
					r[27:24] = a[27:24] + 4'h1;
				end
			end else begin
				r[7:0] = a[7:0] + 8'h01;
			end
		end
		return r;
	endfunction

	atw_dev_s    q;
	atw_dev_s    n;
	logic [15:0] sector_buf [0:255];
	logic [7:0]  ecc_buf [0:ECC_DEPTH-1];
	logic        buf_we;
	logic        ecc_we;
	logic [7:0]  status;
	logic        busy;
	logic        drq;
	logic [5:0]  ecc_need;
	logic [27:0] cur_addr;

	assign busy     = (q.st != S_IDLE);
	assign drq      = (q.st == S_BUF_WR) || (q.st == S_BUF_RD) || (q.st == S_DMA)
	                  || (q.st == S_LONG) || (q.st == S_ECC);
	assign ecc_need = q.ecc40 ? ECC_LONG : ECC_SHORT;
	assign cur_addr = {q.drvhd[3:0], q.trk_hi, q.trk_lo, q.sect};

	always_comb begin
		status         = 8'h00;
		status[ST_BSY] = (q.st == S_MEDIA);
		status[ST_RDY] = 1'b1;
		status[ST_DSC] = 1'b1;
		status[ST_DRQ] = drq;
		status[ST_ERR] = q.err;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n          = q;
		n.media_wr = 1'b0;
		buf_we     = 1'b0;
		ecc_we     = 1'b0;
		if (media_idx < ECC_BASE) begin
			n.media_word = sector_buf[media_idx[7:0]];
		end else if (media_idx - ECC_BASE < ECC_LONG) begin
			n.media_word = {8'h00, ecc_buf[6'(media_idx - ECC_BASE)]};
		end else begin
			n.media_word = 16'h0000;
		end
		if (ecc_sel_load) begin
			n.ecc40 = ecc_sel_40;
		end

		// reads; a status read drops the interrupt, a set below wins
		if (link.rd) begin
			case (link.addr)
				TF_DATA: begin
					n.rdata = sector_buf[q.ptr[7:0]];
					if (q.st == S_BUF_RD) begin
						n.ptr = q.ptr + 9'h001;
						if (q.ptr == LAST_WORD) begin
							n.st    = S_IDLE;
							n.intrq = 1'b1;
						end
					end
				end
				TF_ERR:    n.rdata = {8'h00, q.err_reg};
				TF_COUNT:  n.rdata = {8'h00, q.count};
				TF_SECT:   n.rdata = {8'h00, q.sect};
				TF_TRK_LO: n.rdata = {8'h00, q.trk_lo};
				TF_TRK_HI: n.rdata = {8'h00, q.trk_hi};
				TF_DRVHD:  n.rdata = {8'h00, q.drvhd};
				default: begin
					n.rdata = {8'h00, status};
					n.intrq = 1'b0;
				end
			endcase
		end

		if (link.wr) begin
			case (link.addr)
				TF_DATA: begin
					if (q.st == S_BUF_WR || q.st == S_LONG) begin
						buf_we = 1'b1;
						n.ptr  = q.ptr + 9'h001;
						if (q.ptr == LAST_WORD) begin
							if (q.st == S_BUF_WR) begin
								n.st    = S_IDLE;
								n.intrq = 1'b1;
							end else begin
								n.st      = S_ECC;
								n.ecc_idx = 6'h00;
							end
						end
					end else if (q.st == S_ECC) begin
						ecc_we    = 1'b1;
						n.ecc_idx = q.ecc_idx + 6'h01;
						if (q.ecc_idx == ecc_need - 6'h01) begin
							n.st       = S_MEDIA;
							n.media_wr = 1'b1;
						end
					end
				end
				TF_CMD: begin
					if (!busy) begin
						n.err      = 1'b0;
						n.err_reg  = 8'h00;
						n.intrq    = 1'b0;
						n.ptr      = 9'h000;
						n.long_cmd = 1'b0;
						if (link.wdata[7:0] == CMD_BUF_WR) begin
							n.st = S_BUF_WR;
						end else if (link.wdata[7:0] == CMD_BUF_RD) begin
							n.st = S_BUF_RD;
						end else if (link.wdata[7:1] == CMD_DMA_WR[7:1]) begin
							n.st     = S_DMA;
							n.remain = (q.count == 8'h00) ? SECTOR_MAX : {1'b0, q.count};
						end else if (link.wdata[7:1] == CMD_LONG_WR[7:1]) begin
							n.st       = S_LONG;
							n.long_cmd = 1'b1;
							n.remain   = 9'h001;
						end else begin
							n.err             = 1'b1;
							n.err_reg[ER_ABT] = 1'b1;
							n.intrq           = 1'b1;
						end
					end
				end
				TF_COUNT:  if (!busy) n.count  = link.wdata[7:0];
				TF_SECT:   if (!busy) n.sect   = link.wdata[7:0];
				TF_TRK_LO: if (!busy) n.trk_lo = link.wdata[7:0];
				TF_TRK_HI: if (!busy) n.trk_hi = link.wdata[7:0];
				TF_DRVHD:  if (!busy) n.drvhd  = link.wdata[7:0];
				default: begin
				end
			endcase
		end

		// dma words only land while this end asks for them
		if (link.dmack && q.st == S_DMA) begin
			buf_we = 1'b1;
			n.ptr  = q.ptr + 9'h001;
			if (q.ptr == LAST_WORD) begin
				n.st       = S_MEDIA;
				n.media_wr = 1'b1;
			end
		end

		if (q.st == S_MEDIA && media_done) begin
			n.st = S_IDLE;
			if (media_unc) begin
				n.err             = 1'b1;
				n.err_reg[ER_UNC] = 1'b1;
				n.count           = q.remain[7:0];
				n.intrq           = 1'b1;
			end else begin
				n.remain = q.remain - 9'h001;
				n.count  = n.remain[7:0];
				if (n.remain == 9'h000) begin
					n.intrq = 1'b1;
				end else begin
					{n.drvhd[3:0], n.trk_hi, n.trk_lo, n.sect} =
						atw_next_addr(q.drvhd[DH_LBA], cur_addr);
					n.ptr = 9'h000;
					n.st  = S_DMA;
				end
			end
		end

		n.dmarq = (n.st == S_DMA);
	end

	// ----------------------------------------
	// registers and memories
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// no reset on the arrays: contents are defined by the next transfer
	always_ff @(posedge clk) begin
		if (buf_we) begin
			sector_buf[q.ptr[7:0]] <= link.wdata;
		end
		if (ecc_we) begin
			ecc_buf[q.ecc_idx] <= link.wdata[7:0];
		end
	end

	assign link.rdata     = q.rdata;
	assign link.dmarq     = q.dmarq;
	assign link.intrq     = q.intrq;
	assign media_wr       = q.media_wr;
	assign media_long     = q.long_cmd;
	assign media_lba_mode = q.drvhd[DH_LBA];
	assign media_addr     = cur_addr;
	assign media_ecc_len  = ecc_need;
	assign media_word     = q.media_word;

endmodule // atw_dev

// >>> verilog/atw_pkg.sv
package atw_pkg;

	// ----------------------------------------
	// task-file register addresses on the link
	// ----------------------------------------
	localparam logic [2:0] TF_DATA   = 3'h0;
	localparam logic [2:0] TF_ERR    = 3'h1;
	localparam logic [2:0] TF_COUNT  = 3'h2;
	localparam logic [2:0] TF_SECT   = 3'h3;
	localparam logic [2:0] TF_TRK_LO = 3'h4;
	localparam logic [2:0] TF_TRK_HI = 3'h5;
	localparam logic [2:0] TF_DRVHD  = 3'h6;
	localparam logic [2:0] TF_CMD    = 3'h7;

	// ----------------------------------------
	// opcodes; bit 0 of dma and long writes is a don't-care
	// ----------------------------------------
	localparam logic [7:0] CMD_BUF_WR  = 8'hE8;
	localparam logic [7:0] CMD_BUF_RD  = 8'hE4;
	localparam logic [7:0] CMD_DMA_WR  = 8'hCA;
	localparam logic [7:0] CMD_LONG_WR = 8'h32;

	// ----------------------------------------
	// status, error and drive/head bit positions
	// ----------------------------------------
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_UNC = 6;
	localparam int ER_ABT = 2;
	localparam int DH_LBA = 6;

	// ----------------------------------------
	// sizes and geometry
	// ----------------------------------------
	localparam logic [8:0] LAST_WORD   = 9'h0FF;
	localparam logic [8:0] SECTOR_MAX  = 9'h100;
	localparam logic [8:0] ECC_BASE    = 9'h100;
	localparam int         ECC_DEPTH   = 40;
	localparam logic [5:0] ECC_SHORT   = 6'h04;
	localparam logic [5:0] ECC_LONG    = 6'h28;
	localparam logic [7:0] SECT_PER_TRK = 8'h3F;
	localparam logic [3:0] HEAD_LAST   = 4'hF;

	// ----------------------------------------
	// host controller register map (axi4-lite)
	// ----------------------------------------
	localparam logic [7:0] HA_TF_WRITE = 8'h00;
	localparam logic [7:0] HA_TF_READ  = 8'h04;
	localparam logic [7:0] HA_DMA      = 8'h08;
	localparam int         HF_ADDR_LSB = 16;
	localparam int         HF_ADDR_MSB = 18;
	localparam int         HF_VALID    = 31;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> verilog/atw_link_if.sv
`timescale 1ns/10ps
interface atw_link_if;
	logic [2:0]  addr;
	logic        wr;
	logic        rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        dmarq;
	logic        dmack;
	logic        intrq;

	modport dev  (input addr, wr, rd, wdata, dmack, output rdata, dmarq, intrq);
	modport host (output addr, wr, rd, wdata, dmack, input rdata, dmarq, intrq);
endinterface

// >>> verilog/atw_host.sv
`timescale 1ns/10ps
module atw_host (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	atw_link_if.host         link,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output wire logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output wire logic        s_axi_wready,
	output wire logic [1:0]  s_axi_bresp,
	output wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output wire logic        s_axi_arready,
	output wire logic [31:0] s_axi_rdata,
	output wire logic [1:0]  s_axi_rresp,
	output wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import atw_pkg::*;

	typedef struct packed {
		logic [2:0]  addr;
		logic        wr;
		logic        rd;
		logic        rd_q;
		logic [15:0] wdata;
		logic        dmack;
		logic [15:0] tf_rdata;
		logic        tf_valid;
		logic [15:0] dma_word;
		logic        dma_pend;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} atw_host_s;

	atw_host_s q;
	atw_host_s n;
	logic      aw_take;
	logic      ar_take;

	// address and data taken together; byte strobes are not honoured
	assign aw_take = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
	assign ar_take = s_axi_arvalid && !q.rvalid;

	always_comb begin
		n       = q;
		n.wr    = 1'b0;
		n.rd    = 1'b0;
		n.dmack = 1'b0;
		n.rd_q  = q.rd;
		if (q.rd_q) begin
			n.tf_rdata = link.rdata;
			n.tf_valid = 1'b1;
		end
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end

		if (aw_take) begin
			n.bvalid = 1'b1;
			n.bresp  = RESP_OKAY;
			case (s_axi_awaddr[7:0])
				HA_TF_WRITE: begin
					n.wr    = 1'b1;
					n.addr  = s_axi_wdata[HF_ADDR_MSB:HF_ADDR_LSB];
					n.wdata = s_axi_wdata[15:0];
				end
				HA_TF_READ: begin
					n.rd       = 1'b1;
					n.addr     = s_axi_wdata[HF_ADDR_MSB:HF_ADDR_LSB];
					n.tf_valid = 1'b0;
				end
				HA_DMA: begin
					n.dma_word = s_axi_wdata[15:0];
					n.dma_pend = 1'b1;
				end
				default: n.bresp = RESP_SLVERR;
			endcase
		end else if (q.dma_pend && link.dmarq && !q.dmack) begin
			// one word per request; the gap lets dmarq settle after each take
			n.dmack    = 1'b1;
			n.wdata    = q.dma_word;
			n.dma_pend = 1'b0;
		end

		if (ar_take) begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			case (s_axi_araddr[7:0])
				HA_TF_READ: begin
					n.rdata[15:0]     = q.tf_rdata;
					n.rdata[HF_VALID] = q.tf_valid;
				end
				HA_DMA:  n.rdata[2:0] = {link.intrq, link.dmarq, q.dma_pend};
				default: n.rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign link.addr     = q.addr;
	assign link.wr       = q.wr;
	assign link.rd       = q.rd;
	assign link.wdata    = q.wdata;
	assign link.dmack    = q.dmack;
	assign s_axi_awready = aw_take;
	assign s_axi_wready  = aw_take;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = ar_take;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rdata   = q.rdata;

endmodule // atw_host

// >>> tb/atw_link_monitor.sv
`timescale 1ns/10ps
module atw_link_monitor (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [2:0]  addr,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic        dmarq,
	input wire logic        dmack,
	input wire logic        intrq
);
	import atw_pkg::*;
	// ----------------
	// words per command
	// ----------------
	logic [9:0] wcnt;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			wcnt <= 10'h000;
		else if (wr && addr == TF_CMD)
			wcnt <= 10'h000;
		else if (dmack && dmarq)
			wcnt <= wcnt + 10'h001;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_rdata_hold; !rd |=> $stable(rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
	property p_sect_end;
		$fell(dmarq) |-> (wcnt[7:0] == 8'h00 && wcnt != 10'h000);
	endproperty
	a_sect_end: assert property (p_sect_end) else $error("dmarq fell mid sector");
	property p_dma_go;
		wr && addr == TF_CMD && wdata[7:1] == CMD_DMA_WR[7:1] |=> dmarq;
	endproperty
	a_dma_go: assert property (p_dma_go) else $error("no dmarq");
	property p_long_pio;
		wr && addr == TF_CMD && wdata[7:1] == CMD_LONG_WR[7:1] |=> (!dmarq) [*8];
	endproperty
	a_long_pio: assert property (p_long_pio) else $error("dmarq in long");
	property p_irq_end; dmarq |-> !intrq; endproperty
	a_irq_end: assert property (p_irq_end) else $error("early intrq");
	property p_irq_hold;
		intrq && !(rd && addr == TF_CMD) && !(wr && addr == TF_CMD) |=> intrq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("intrq dropped");
	property p_irq_clr; rd && addr == TF_CMD |=> !intrq; endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("intrq kept");
	property p_stat;
		rd && addr == TF_CMD |=> rdata[ST_RDY] && rdata[ST_DSC];
	endproperty
	a_stat: assert property (p_stat) else $error("status bits");
	c_sect: cover property ($fell(dmarq));
	c_irq: cover property ($rose(intrq));
	c_go: cover property (wr && addr == TF_CMD ##1 dmarq);
endmodule // atw_link_monitor

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import atw_pkg::*;
	logic             clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic [7:0]       awa = 8'h00;
	logic [7:0]       ara = 8'h00;
	logic [31:0]      wd = 32'h0000_0000;
	logic             awv = 1'b0;
	logic             wv = 1'b0;
	logic             bre = 1'b0;
	logic             arv = 1'b0;
	logic             rre = 1'b0;
	logic             ecc_ld = 1'b0;
	logic             ecc40 = 1'b0;
	logic             mdone = 1'b0;
	logic             munc = 1'b0;
	logic [2:0]       mdl = 3'h0;
	logic             irq_d = 1'b0;
	logic [8:0]       midx = 9'h103;
	wire logic        awr, wrdy, bv, arr, rv, mwr, mlong, mlba;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdat;
	wire logic [27:0] maddr;
	wire logic [5:0]  mlen;
	wire logic [15:0] mword;
	logic [27:0]      madr, a;
	logic [5:0]       mlq;
	logic             mgq;
	logic [1:0]       resp;
	logic [31:0]      seed = 32'h0001_12ac;
	logic [31:0]      v;
	logic [15:0]      bf [256];
	logic [7:0]       ec [40];
	int               fails = 0, compares = 0, cyc = 0, nwr = 0, nirq = 0, unc_at = 0;
	int               n0, i0, n;
	atw_link_if lk ();
	atw_dev atw_dev_i (.clk(clk), .sys_rst(sys_rst), .link(lk), .ecc_sel_load(ecc_ld),
		.ecc_sel_40(ecc40), .media_wr(mwr), .media_long(mlong), .media_lba_mode(mlba),
		.media_addr(maddr), .media_ecc_len(mlen), .media_idx(midx), .media_word(mword),
		.media_done(mdone), .media_unc(munc));
	atw_host atw_host_i (.clk(clk), .sys_rst(sys_rst), .link(lk),
		.s_axi_awaddr({24'h00_0000, awa}), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr({24'h00_0000, ara}), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre));
	atw_link_monitor atw_link_monitor_i (.clk(clk), .sys_rst(sys_rst), .addr(lk.addr),
		.wr(lk.wr), .rd(lk.rd), .wdata(lk.wdata), .rdata(lk.rdata), .dmarq(lk.dmarq),
		.dmack(lk.dmack), .intrq(lk.intrq));
	always #5 clk = ~clk;
	// ----------------
	// media stand-in
	// ----------------
	always @(posedge clk) begin
		mdl <= {mdl[1:0], mwr};
		mdone <= mdl[2];
		munc <= (nwr == unc_at);
		irq_d <= lk.intrq;
		cyc <= cyc + 1;
		if (lk.intrq && !irq_d)
			nirq <= nirq + 1;
		if (mwr) begin
			nwr <= nwr + 1;
			madr <= maddr;
			mlq <= mlen;
			mgq <= mlong;
		end
		if (cyc == 90000) begin
			fails = fails + 1;
			give_verdict();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// chs steps sector, then head, then track
	function automatic logic [27:0] nxt(input logic [27:0] p, input logic l);
		if (l || p[7:0] != SECT_PER_TRK)
			return p + 28'h000_0001;
		if (p[27:24] != HEAD_LAST)
			return {p[27:24] + 4'h1, p[23:8], 8'h01};
		return {4'h0, p[23:8] + 16'h0001, 8'h01};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic give_verdict();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		awa <= ad;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do @(negedge clk); while (!(awr && wrdy));
		@(posedge clk);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(negedge clk); while (bv !== 1'b1);
		resp = bresp;
		@(posedge clk);
		bre <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] ad);
		@(posedge clk);
		ara <= ad;
		arv <= 1'b1;
		rre <= 1'b1;
		do @(negedge clk); while (!arr);
		@(posedge clk);
		arv <= 1'b0;
		do @(negedge clk); while (rv !== 1'b1);
		v = rdat;
		resp = rresp;
		@(posedge clk);
		rre <= 1'b0;
	endtask
	task automatic lw(input logic [2:0] r, input logic [15:0] d);
		axw(HA_TF_WRITE, {13'h0000, r, d});
	endtask
	task automatic lr(input logic [2:0] r);
		axw(HA_TF_READ, {13'h0000, r, 16'h0000});
		do axr(HA_TF_READ); while (!v[HF_VALID]);
		v = {16'h0000, v[15:0]};
	endtask
	task automatic setup(input logic [7:0] c, input logic l, input logic [27:0] p);
		lw(TF_COUNT, {8'h00, c});
		lw(TF_SECT, {8'h00, p[7:0]});
		lw(TF_TRK_LO, {8'h00, p[15:8]});
		lw(TF_TRK_HI, {8'h00, p[23:16]});
		lw(TF_DRVHD, {9'h001, l, 2'h2, p[27:24]});
	endtask
	task automatic waitirq();
		do axr(HA_DMA); while (!v[2]);
	endtask
	task automatic dmarun(input logic [7:0] c, input logic l, input logic [7:0] op,
		input int u, input logic [7:0] rem, input logic [27:0] ea);
		logic [31:0] e;
		n0 = nwr;
		i0 = nirq;
		unc_at = (u == 0) ? 0 : nwr + u;
		setup(c, l, a);
		lw(TF_CMD, {8'h00, op});
		repeat (512) begin
			axw(HA_DMA, {16'h0000, 16'(rnd())});
			do axr(HA_DMA); while (v[0]);
		end
		waitirq();
		chk(nwr - n0, 2);
		chk(nirq - i0, 1);
		chk({3'h0, mlba, madr}, {3'h0, l, ea});
		lr(TF_COUNT);
		chk(v, {24'h00_0000, rem});
		e = {4'h0, ea};
		for (int i = 0; i < 4; i++) begin
			lr(3'(TF_SECT + i));
			chk(v & (i == 3 ? 32'h0000_000f : 32'h0000_00ff), (e >> (8 * i)) & 32'h0000_00ff);
		end
		lr(TF_ERR);
		chk(v, (u == 0) ? 32'h0000_0000 : 32'h0000_0040);
		lr(TF_CMD);
		chk(v & 32'h0000_0089, (u == 0) ? 32'h0000_0000 : 32'h0000_0001);
	endtask
	// ----------------
	// main sequence
	// ----------------
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		axr(8'h00);
		chk(resp, RESP_SLVERR);
		axw(8'h0c, 32'h0000_0000);
		chk(resp, RESP_SLVERR);
		lw(TF_CMD, {8'h00, CMD_BUF_WR});
		for (int i = 0; i < 256; i++) begin
			bf[i] = 16'(rnd());
			lw(TF_DATA, bf[i]);
		end
		lr(TF_CMD);
		chk(v, 32'h0000_0050);
		chk(nwr, 0);
		lw(TF_CMD, {8'h00, CMD_BUF_RD});
		for (int i = 0; i < 256; i++) begin
			lr(TF_DATA);
			chk(v, {16'h0000, bf[i]});
		end
		// opcode one bit off the dma write must abort
		lw(TF_CMD, 16'h00c8);
		lr(TF_ERR);
		chk(v, 32'h0000_0004);
		lr(TF_CMD);
		chk(v, 32'h0000_0051);
		// last sector of last head forces a track step
		a = {4'hf, 16'(rnd()), SECT_PER_TRK};
		dmarun(8'h00, 1'b0, CMD_DMA_WR, 2, 8'hff, nxt(a, 1'b0));
		a = 28'(rnd());
		dmarun(8'h02, 1'b1, CMD_DMA_WR | 8'h01, 0, 8'h00, nxt(a, 1'b1));
		for (int k = 0; k < 2; k++) begin
			n = k ? 40 : 4;
			if (k) begin
				@(posedge clk);
				ecc40 <= 1'b1;
				ecc_ld <= 1'b1;
				@(posedge clk);
				ecc_ld <= 1'b0;
			end
			n0 = nwr;
			a = 28'(rnd());
			setup(8'h01, 1'b0, a);
			lw(TF_CMD, {8'h00, k ? CMD_LONG_WR : CMD_LONG_WR | 8'h01});
			for (int i = 0; i < 256; i++) begin
				bf[i] = 16'(rnd());
				lw(TF_DATA, bf[i]);
			end
			for (int j = 0; j < n; j++) begin
				lr(TF_CMD);
				chk({v[ST_DRQ], 1'(nwr == n0)}, 2'b11);
				ec[j] = 8'(rnd());
				lw(TF_DATA, {8'h00, ec[j]});
			end
			waitirq();
			chk({mgq, mlq}, {1'b1, k ? ECC_LONG : ECC_SHORT});
			// media side walks to the last ecc byte, then the last data word
			midx <= ECC_BASE + 9'(n - 1);
			repeat (2) @(negedge clk);
			chk(mword[7:0], ec[n - 1]);
			@(posedge clk);
			midx <= LAST_WORD;
			repeat (2) @(negedge clk);
			chk(mword, bf[255]);
			chk({4'h0, madr}, {4'h0, a});
			lr(TF_CMD);
			chk(v & 32'h0000_0089, 32'h0000_0000);
			chk(nwr - n0, 1);
		end
		// reset in mid-run must bring back the short ecc length
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk(mlen, ECC_SHORT);
		lr(TF_CMD);
		chk(v, 32'h0000_0050);
		give_verdict();
	end
endmodule // testbench
